// ===== rtl/svd_params.svh
// constants for the supply voltage detect control block
`ifndef SVD_PARAMS_SVH
`define SVD_PARAMS_SVH

// ==========================================================
// register byte addresses
`define SVD_ADDR_LIMIT   12'h000
`define SVD_ADDR_CTRL    12'h004
`define SVD_ADDR_IRQ     12'h008
`define SVD_ADDR_POWER   12'h00c

// ==========================================================
// field positions
`define SVD_CTRL_EN      7
`define SVD_CTRL_OUT     5
`define SVD_CTRL_RDY     4
`define SVD_CTRL_RISE    1
`define SVD_CTRL_FALL    0
`define SVD_IRQ_FLAG     0
`define SVD_IRQ_IE       1
`define SVD_IRQ_PRIO     2
`define SVD_PWR_SLEEP    0
`define SVD_PWR_FREEZE   1
`define SVD_PWR_POR      2

// ==========================================================
// reset values
`define SVD_LIMIT_RST    4'h0
`define SVD_SYNC_RST     2'h0

// ==========================================================
// bus answers
`define SVD_RESP_OKAY    2'h0
`define SVD_RESP_SLVERR  2'h2

`endif

// ===== rtl/svd_pkg.sv
// types for the supply voltage detect control block
package svd_pkg;

  // ==========================================================
  // bus channel carriers
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } svd_wreq_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } svd_rrsp_t;

  // ==========================================================
  // write channel state
  typedef enum logic [1:0] {
    SVD_W_IDLE = 2'b00,
    SVD_W_RESP = 2'b01
  } svd_wstate_t;

endpackage : svd_pkg

// ===== rtl/svd_sync2.sv
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module svd_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : svd_sync2
`default_nettype wire

// ===== rtl/svd_ctrl.sv
// supply voltage detect control with axi4-lite registers
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "svd_params.svh"

// Function
// R01: detection runs on the system clock, not the stopped instruction clock, in sleep.
// R02: enabled crossing in sleep sets the flag and raises a wake request.
// R03: processor resumes at the vector only when global interrupts are enabled.
// R04: idle and doze keep the detector active and generating events.
// R05: freeze blocks any new detect event or interrupt request.
// R06: during freeze the ready status holds its value from freeze entry.
// R07: registers stay readable and writable during freeze.
// R08: any reset returns registers to reset values, switching the detector off; system reset leaves the limit select unchanged here.
// R09: limit select sits in bits 3:0; code 1111 reserved.
// R10: limit register bits 7:4 read zero and ignore writes.
// R11: control bit 7 powers the detector and its reference.
// R12: control bit 5 reads the comparator output, one at or below limit.
// R13: control bit 4 reads one once the reference is stable.
// R14: control bit 1 enables rising detection.
// R15: control bit 0 enables falling detection.
// R16: control bits 6, 3 and 2 read zero.
// R17: limit select resets only on power-on; enable and directions on every reset.
// R18: no detect interrupt until enabled and ready status set.
// R19: software disables the detector before changing limit or directions.
// R20: flag stays set until written zero; request is flag and enable.
// R21: comparator and ready are synchronised; crossings are edges of the output.
module svd_ctrl (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        POR_I,
  // axi4-lite write address
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [11:0] S_AXI_AWADDR_I,
  // axi4-lite write data
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  // axi4-lite write response
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  output logic [1:0]       S_AXI_BRESP_O,
  // axi4-lite read address
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  input  wire logic [11:0] S_AXI_ARADDR_I,
  // axi4-lite read data
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  // analog detector
  input  wire logic        CMP_OUT_I,
  input  wire logic        REF_READY_I,
  output logic             DET_POWER_EN_O,
  output logic [3:0]       TRIP_LIMIT_O,
  // system
  output logic             IRQ_O,
  output logic             WAKE_REQ_O
);

  // ==========================================================
  // register state
  logic [3:0]  trip_limit_field_r;
  logic        detector_power_enable_r;
  logic        rising_detect_enable_r;
  logic        falling_detect_enable_r;
  logic        voltage_detect_flag_r;
  logic        voltage_detect_irq_enable_r;
  logic        voltage_detect_irq_priority_r;
  logic        sleep_r;
  logic        freeze_r;
  logic        reference_ready_status_r;
  logic        cmp_prev_r;
  logic        cmp_sync;
  logic        rdy_sync;
  logic        crossing;
  logic        detect_event;

  // ==========================================================
  // input synchronisers
  svd_sync2 u_sync_cmp (
    .clk_i (SYS_CLK_I),
    .rst_i (SRST_I),
    .d_i   (CMP_OUT_I),
    .q_o   (cmp_sync)
  ); // R21
  svd_sync2 u_sync_rdy (
    .clk_i (SYS_CLK_I),
    .rst_i (SRST_I),
    .d_i   (REF_READY_I),
    .q_o   (rdy_sync)
  ); // R21

  // ==========================================================
  // axi4-lite write channel
  svd_pkg::svd_wstate_t wstate_r;
  svd_pkg::svd_wreq_t   wreq_r;
  logic                 aw_held_r;
  logic                 w_held_r;
  logic                 wr_fire;
  logic                 aw_take;
  logic                 w_take;

  assign S_AXI_AWREADY_O = (wstate_r == svd_pkg::SVD_W_IDLE) && !aw_held_r;
  assign S_AXI_WREADY_O  = (wstate_r == svd_pkg::SVD_W_IDLE) && !w_held_r;
  assign aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_take  = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign wr_fire = (wstate_r == svd_pkg::SVD_W_IDLE) &&
                   (aw_held_r || aw_take) && (w_held_r || w_take);
  assign S_AXI_BVALID_O = (wstate_r == svd_pkg::SVD_W_RESP);

  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane0;
  assign wr_addr  = aw_held_r ? wreq_r.addr : S_AXI_AWADDR_I;
  assign wr_data  = w_held_r  ? wreq_r.data : S_AXI_WDATA_I;
  assign wr_lane0 = w_held_r  ? wreq_r.strb[0] : S_AXI_WSTRB_I[0];

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      wstate_r  <= svd_pkg::SVD_W_IDLE;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      wreq_r    <= '0;
      S_AXI_BRESP_O <= `SVD_RESP_OKAY;
    end else begin
      unique case (wstate_r)
        svd_pkg::SVD_W_IDLE: begin
          if (wr_fire) begin
            wstate_r  <= svd_pkg::SVD_W_RESP;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            S_AXI_BRESP_O <= (wr_addr[11:4] == 8'h00 && wr_addr[1:0] == 2'h0) ?
                             `SVD_RESP_OKAY : `SVD_RESP_SLVERR;
          end else begin
            if (aw_take) begin
              aw_held_r   <= 1'b1;
              wreq_r.addr <= S_AXI_AWADDR_I;
            end
            if (w_take) begin
              w_held_r    <= 1'b1;
              wreq_r.data <= S_AXI_WDATA_I;
              wreq_r.strb <= S_AXI_WSTRB_I;
            end
          end
        end
        svd_pkg::SVD_W_RESP: begin
          if (S_AXI_BREADY_I) begin
            wstate_r <= svd_pkg::SVD_W_IDLE;
          end
        end
      endcase
    end
  end

  // register writes accepted whatever the freeze state
  logic wr_limit;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_pwr;
  assign wr_limit = wr_fire && wr_lane0 && (wr_addr == `SVD_ADDR_LIMIT); // R07
  assign wr_ctrl  = wr_fire && wr_lane0 && (wr_addr == `SVD_ADDR_CTRL);  // R07
  assign wr_irq   = wr_fire && wr_lane0 && (wr_addr == `SVD_ADDR_IRQ);
  assign wr_pwr   = wr_fire && wr_lane0 && (wr_addr == `SVD_ADDR_POWER);

  // ==========================================================
  // limit register, cleared only by power-on reset
  always_ff @(posedge SYS_CLK_I) begin
    if (POR_I) begin
      trip_limit_field_r <= `SVD_LIMIT_RST; // R17
    end else if (wr_limit) begin
      trip_limit_field_r <= wr_data[3:0]; // R09 R10
    end
  end
  assign TRIP_LIMIT_O = trip_limit_field_r;

  // ==========================================================
  // control register
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || POR_I) begin
      detector_power_enable_r <= 1'b0; // R08 R17
      rising_detect_enable_r  <= 1'b0; // R17
      falling_detect_enable_r <= 1'b0; // R17
    end else if (wr_ctrl) begin
      detector_power_enable_r <= wr_data[`SVD_CTRL_EN];   // R11
      rising_detect_enable_r  <= wr_data[`SVD_CTRL_RISE]; // R14
      falling_detect_enable_r <= wr_data[`SVD_CTRL_FALL]; // R15
    end
  end
  assign DET_POWER_EN_O = detector_power_enable_r; // R11

  // ==========================================================
  // power mode bits
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || POR_I) begin
      sleep_r  <= 1'b0;
      freeze_r <= 1'b0;
    end else if (wr_pwr) begin
      sleep_r  <= wr_data[`SVD_PWR_SLEEP];
      freeze_r <= wr_data[`SVD_PWR_FREEZE];
    end
  end

  // ==========================================================
  // ready status, held during freeze
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || POR_I) begin
      reference_ready_status_r <= 1'b0;
    end else if (!freeze_r) begin
      reference_ready_status_r <= rdy_sync && detector_power_enable_r; // R06 R13
    end
  end

  // ==========================================================
  // crossing detection
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || POR_I) begin
      cmp_prev_r <= 1'b0;
    end else begin
      cmp_prev_r <= cmp_sync;
    end
  end

  // output high means supply at or below the limit
  assign crossing = (rising_detect_enable_r && cmp_prev_r && !cmp_sync) ||
                    (falling_detect_enable_r && !cmp_prev_r && cmp_sync); // R14 R15 R21
  // events run on the system clock in every power mode except freeze, which blocks them
  assign detect_event = crossing && detector_power_enable_r &&
                        reference_ready_status_r && !freeze_r; // R01 R04 R05 R18

  // ==========================================================
  // flag and interrupt control, set wins over clear
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || POR_I) begin
      voltage_detect_flag_r         <= 1'b0;
      voltage_detect_irq_enable_r   <= 1'b0;
      voltage_detect_irq_priority_r <= 1'b0;
    end else begin
      if (detect_event) begin
        voltage_detect_flag_r <= 1'b1; // R02 R20
      end else if (wr_irq && !wr_data[`SVD_IRQ_FLAG]) begin
        voltage_detect_flag_r <= 1'b0; // R20
      end
      if (wr_irq) begin
        voltage_detect_irq_enable_r   <= wr_data[`SVD_IRQ_IE];
        voltage_detect_irq_priority_r <= wr_data[`SVD_IRQ_PRIO];
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I || POR_I) begin
      IRQ_O      <= 1'b0;
      WAKE_REQ_O <= 1'b0;
    end else begin
      IRQ_O      <= voltage_detect_flag_r && voltage_detect_irq_enable_r && !freeze_r; // R05 R20
      WAKE_REQ_O <= sleep_r && voltage_detect_flag_r; // R02
    end
  end

  // ==========================================================
  // axi4-lite read channel
  svd_pkg::svd_rrsp_t rd_nxt;
  logic               rvalid_r;

  always_comb begin
    rd_nxt = '0;
    unique case (S_AXI_ARADDR_I)
      `SVD_ADDR_LIMIT: rd_nxt.data = {28'h0000000, trip_limit_field_r}; // R10
      `SVD_ADDR_CTRL:  rd_nxt.data = {24'h000000, detector_power_enable_r, 1'b0,
                                      cmp_sync, reference_ready_status_r, 2'b00,
                                      rising_detect_enable_r,
                                      falling_detect_enable_r}; // R12 R13 R16
      `SVD_ADDR_IRQ:   rd_nxt.data = {29'h00000000, voltage_detect_irq_priority_r,
                                      voltage_detect_irq_enable_r, voltage_detect_flag_r};
      `SVD_ADDR_POWER: rd_nxt.data = {30'h00000000, freeze_r, sleep_r};
      default:         rd_nxt.resp = `SVD_RESP_SLVERR;
    endcase
  end

  assign S_AXI_ARREADY_O = !rvalid_r;
  assign S_AXI_RVALID_O  = rvalid_r;

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      rvalid_r      <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `SVD_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && !rvalid_r) begin
      rvalid_r      <= 1'b1;
      S_AXI_RDATA_O <= rd_nxt.data; // R07
      S_AXI_RRESP_O <= rd_nxt.resp;
    end else if (rvalid_r && S_AXI_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  property p_freeze_no_event;
    @(posedge SYS_CLK_I) disable iff (SRST_I)
      freeze_r |-> !detect_event;
  endproperty
  a_freeze_no_event: assert property (p_freeze_no_event) else $error("event in freeze"); // R05

  property p_ready_hold;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      $past(freeze_r) |-> $stable(reference_ready_status_r);
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready moved in freeze"); // R06

  property p_flag_needs_ready;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      $rose(voltage_detect_flag_r) |-> $past(reference_ready_status_r) &&
                                       $past(detector_power_enable_r);
  endproperty
  a_flag_needs_ready: assert property (p_flag_needs_ready) else $error("flag before ready"); // R18

  property p_flag_sticky;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      voltage_detect_flag_r && !(wr_irq && !wr_data[`SVD_IRQ_FLAG]) |=> voltage_detect_flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // R20

  property p_irq_follow;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      voltage_detect_flag_r && voltage_detect_irq_enable_r && !freeze_r |=> IRQ_O;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing"); // R20

  property p_wake;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      sleep_r && detect_event |-> ##2 WAKE_REQ_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in sleep"); // R02

  property p_rising;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      detector_power_enable_r && reference_ready_status_r && !freeze_r &&
      rising_detect_enable_r && $fell(cmp_sync) |=> voltage_detect_flag_r;
  endproperty
  a_rising: assert property (p_rising) else $error("rise missed"); // R14

  property p_falling;
    @(posedge SYS_CLK_I) disable iff (SRST_I || POR_I)
      detector_power_enable_r && reference_ready_status_r && !freeze_r &&
      falling_detect_enable_r && $rose(cmp_sync) |=> voltage_detect_flag_r;
  endproperty
  a_falling: assert property (p_falling) else $error("fall missed"); // R15

  property p_reset_off;
    @(posedge SYS_CLK_I) SRST_I |=> !DET_POWER_EN_O;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enable survived reset"); // R08

  property p_limit_bits;
    @(posedge SYS_CLK_I) disable iff (SRST_I)
      S_AXI_RVALID_O && $past(S_AXI_ARADDR_I == `SVD_ADDR_LIMIT && S_AXI_ARVALID_I
                              && !rvalid_r) |-> S_AXI_RDATA_O[31:4] == 28'h0000000;
  endproperty
  a_limit_bits: assert property (p_limit_bits) else $error("limit upper bits set"); // R10

  c_flag_set:  cover property (@(posedge SYS_CLK_I) $rose(voltage_detect_flag_r));
  c_wake:      cover property (@(posedge SYS_CLK_I) $rose(WAKE_REQ_O));
  c_freeze:    cover property (@(posedge SYS_CLK_I) freeze_r && crossing);
  c_write:     cover property (@(posedge SYS_CLK_I) wr_ctrl);

endmodule : svd_ctrl
`default_nettype wire

// ===== verif/svd_afe_model.sv
// analog front end model: comparator and reference behind the detector
`timescale 1ns/100ps
`default_nettype none
module svd_afe_model #(
  parameter int READY_DLY_NS = 200
) (
  // detector control from the block
  input  wire logic       power_en_i,
  input  wire logic [3:0] trip_limit_i,
  // supply level in limit steps
  input  wire logic [4:0] supply_i,
  // analog results
  output logic            cmp_out_o,
  output logic            ref_ready_o
);
  logic ready_r = 1'b0;

  // reference settles a while after power up, drops at once on power down
  always @(posedge power_en_i) begin
    ready_r = 1'b0;
    #(READY_DLY_NS);
    ready_r = power_en_i;
  end

  assign ref_ready_o = ready_r & power_en_i;
  assign cmp_out_o   = power_en_i & (supply_i <= {1'b0, trip_limit_i});
endmodule : svd_afe_model
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking testbench for the supply voltage detect control block
`timescale 1ns/100ps
`default_nettype none
`include "svd_params.svh"
module tb_top;
  logic        sys_clk, srst, por;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, trip_limit;
  logic [1:0]  bresp, rresp;
  logic        cmp_out, ref_ready, det_en, irq, wake;
  logic [4:0]  supply;
  int          num_errors, checked;
  logic        global_irq_enable;

  svd_ctrl uut (.SYS_CLK_I(sys_clk), .SRST_I(srst), .POR_I(por),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .CMP_OUT_I(cmp_out),
    .REF_READY_I(ref_ready), .DET_POWER_EN_O(det_en), .TRIP_LIMIT_O(trip_limit),
    .IRQ_O(irq), .WAKE_REQ_O(wake));

  svd_afe_model afe (.power_en_i(det_en), .trip_limit_i(trip_limit), .supply_i(supply),
    .cmp_out_o(cmp_out), .ref_ready_o(ref_ready));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // common tasks
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc

  task bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit done;
    done = 1'b0;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    for (n = 0; n < 40 && !done; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1'b1;
        chk("write response", {30'h0, er}, {30'h0, bresp});
      end
    end
    if (!done) begin
      chk("write handshake", 32'h1, 32'h0);
      close_out();
    end
  endtask : bus_wr

  task bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    done = 1'b0;
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 40 && !done; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    if (!done) begin
      chk("read handshake", 32'h1, 32'h0);
      close_out();
    end
  endtask : bus_rd

  task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(a, d, r);
    chk(name, exp, d);
  endtask : rd_chk

  task wait_ready;
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h0;
    for (int n = 0; n < 100 && d[`SVD_CTRL_RDY] !== 1'b1; n++) begin
      bus_rd(`SVD_ADDR_CTRL, d, r);
    end
    if (d[`SVD_CTRL_RDY] !== 1'b1) begin
      chk("ready timeout", 32'h1, 32'h0);
      close_out();
    end
  endtask : wait_ready

  // ==========================================================
  // scenarios
  task t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk("limit reset", `SVD_ADDR_LIMIT, 32'h0);
    rd_chk("ctrl reset", `SVD_ADDR_CTRL, 32'h0);
    rd_chk("irq reset", `SVD_ADDR_IRQ, 32'h0);
    bus_rd(12'h010, d, r);
    chk("unmapped resp", {30'h0, `SVD_RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    bus_wr(12'h010, 32'hff, `SVD_RESP_SLVERR);
    bus_wr(`SVD_ADDR_LIMIT, 32'hff, `SVD_RESP_OKAY);
    rd_chk("limit upper bits", `SVD_ADDR_LIMIT, 32'h0f);
    chk("limit pins", 32'hf, {28'h0, trip_limit});
    bus_wr(`SVD_ADDR_LIMIT, 32'h05, `SVD_RESP_OKAY);
  endtask : t_regs

  task t_falling;
    bus_wr(`SVD_ADDR_CTRL, 32'hcf, `SVD_RESP_OKAY);
    chk("power enable", 32'h1, {31'h0, det_en});
    wait_ready();
    rd_chk("ctrl read", `SVD_ADDR_CTRL, 32'h93);
    bus_wr(`SVD_ADDR_IRQ, 32'h02, `SVD_RESP_OKAY);
    supply <= 5'd3;
    wait_cyc(10);
    chk("irq falling", 32'h1, {31'h0, irq});
    rd_chk("ctrl out low supply", `SVD_ADDR_CTRL, 32'hb3);
    bus_wr(`SVD_ADDR_IRQ, 32'h03, `SVD_RESP_OKAY);
    rd_chk("flag holds", `SVD_ADDR_IRQ, 32'h03);
    bus_wr(`SVD_ADDR_IRQ, 32'h02, `SVD_RESP_OKAY);
    wait_cyc(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus_wr(`SVD_ADDR_IRQ, 32'h00, `SVD_RESP_OKAY);
    supply <= 5'd8;
    wait_cyc(10);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd_chk("flag on rise", `SVD_ADDR_IRQ, 32'h01);
  endtask : t_falling

  task t_sleep;
    bus_wr(`SVD_ADDR_CTRL, 32'h00, `SVD_RESP_OKAY);
    bus_wr(`SVD_ADDR_CTRL, 32'h82, `SVD_RESP_OKAY);
    wait_ready();
    bus_wr(`SVD_ADDR_POWER, 32'h01, `SVD_RESP_OKAY);
    bus_wr(`SVD_ADDR_IRQ, 32'h06, `SVD_RESP_OKAY);
    supply <= 5'd3;
    wait_cyc(10);
    rd_chk("falling disabled", `SVD_ADDR_IRQ, 32'h06);
    chk("no wake", 32'h0, {31'h0, wake});
    supply <= 5'd8;
    wait_cyc(10);
    chk("wake on rise", 32'h1, {31'h0, wake});
    chk("irq on rise", 32'h1, {31'h0, irq});
    // processor model: takes the vector only with global interrupts on
    chk("resume at vector", 32'h0, {31'h0, wake & irq & global_irq_enable});
    bus_wr(`SVD_ADDR_IRQ, 32'h02, `SVD_RESP_OKAY);
    wait_cyc(3);
    chk("wake cleared", 32'h0, {31'h0, wake});
    bus_wr(`SVD_ADDR_POWER, 32'h00, `SVD_RESP_OKAY);
  endtask : t_sleep

  task t_freeze;
    bus_wr(`SVD_ADDR_POWER, 32'h02, `SVD_RESP_OKAY);
    supply <= 5'd3;
    wait_cyc(10);
    supply <= 5'd8;
    wait_cyc(10);
    rd_chk("no event in freeze", `SVD_ADDR_IRQ, 32'h02);
    chk("no irq in freeze", 32'h0, {31'h0, irq});
    bus_wr(`SVD_ADDR_CTRL, 32'h00, `SVD_RESP_OKAY);
    chk("power off in freeze", 32'h0, {31'h0, det_en});
    wait_cyc(5);
    rd_chk("ready held", `SVD_ADDR_CTRL, 32'h10);
    bus_wr(`SVD_ADDR_POWER, 32'h00, `SVD_RESP_OKAY);
    wait_cyc(5);
    rd_chk("ready released", `SVD_ADDR_CTRL, 32'h00);
  endtask : t_freeze

  task t_reset;
    bus_wr(`SVD_ADDR_LIMIT, 32'h07, `SVD_RESP_OKAY);
    bus_wr(`SVD_ADDR_CTRL, 32'h83, `SVD_RESP_OKAY);
    @(posedge sys_clk);
    srst <= 1'b1;
    wait_cyc(2);
    srst <= 1'b0;
    wait_cyc(2);
    rd_chk("limit kept", `SVD_ADDR_LIMIT, 32'h07);
    rd_chk("ctrl cleared", `SVD_ADDR_CTRL, 32'h00);
    chk("power off", 32'h0, {31'h0, det_en});
  endtask : t_reset

  initial begin
    num_errors = 0;
    checked = 0;
    global_irq_enable = 1'b0;
    srst = 1'b1;
    por = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    supply = 5'd8;
    wait_cyc(20);
    srst <= 1'b0;
    por <= 1'b0;
    t_regs();
    t_falling();
    t_sleep();
    t_freeze();
    t_reset();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
